// ---- verilog/sgsd_top.sv ----
// speed feedback filter, PI/P speed loop switch and status display
//
// Function
// [R01] first-order filter on speed feedback, time constant 0..65535 x 0.01 ms
// [R02] selector 0: P control while torque command exceeds torque level (percent)
// [R03] selector 1: P control while speed command exceeds speed level
// [R04] selector 2: P control while acceleration command exceeds acceleration level
// [R05] selector 3: P control while deviation pulses exceed deviation level
// [R06] back to PI control once selected quantity no longer exceeds level
// [R07] status display mode is active after power-up
// [R08] lamps for control supply on and main supply on
// [R09] base-block lamp lit with servo off, dimmed with servo on
// [R10] positioning-done lamp while residual pulses below completion range
// [R11] speed-conformity lamp while speed within command plus/minus width
// [R12] rotation lamp while motor speed at or above detection speed
// [R13] command-pulse lamp while command pulses arrive
// [R14] speed-command lamp while speed command at or above detection speed
// [R15] counter-clear lamp while clear input asserted, shared with torque lamp
// [R16] torque control: shared lamp lit at torque command of 10 percent or more
// [R17] symbol bb with servo off, run with servo on
// [R18] symbol Pot when forward prohibit off, not when reverse prohibit off
// [R19] alarm symbol whenever an alarm is active
// [R20] power lamp on normal control power, charge lamp while bus charged
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module sgsd_top #(
	parameter int VAL_W    = 16,
	parameter int HOLD_CYC = sgsd_pkg::PULSE_HOLD_CYC
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic [sgsd_pkg::ADDR_W-1:0] addr,
	input  wire logic [sgsd_pkg::DATA_W-1:0] wdata,
	input  wire logic                        wr,
	input  wire logic                        rd,
	output logic      [sgsd_pkg::DATA_W-1:0] rdata,
	input  wire logic signed [VAL_W-1:0]     speed_fb,
	input  wire logic signed [VAL_W-1:0]     speed_cmd,
	input  wire logic signed [VAL_W-1:0]     torque_cmd,
	input  wire logic signed [VAL_W-1:0]     accel_cmd,
	input  wire logic signed [VAL_W-1:0]     deviation,
	input  wire logic                        servo_on,
	input  wire logic                        torque_mode,
	input  wire logic                        alarm_active,
	input  wire logic [7:0]                  alarm_code,
	input  wire logic                        ctrl_pwr_in,
	input  wire logic                        main_pwr_in,
	input  wire logic                        charge_in,
	input  wire logic                        fwd_permit_in,
	input  wire logic                        rev_permit_in,
	input  wire logic                        cmd_pulse_in,
	input  wire logic                        deviation_counter_clear,
	output logic signed [VAL_W-1:0]          speed_fb_filt,
	output logic                             p_control,
	output logic [sgsd_pkg::LED_N-1:0]       status_leds,
	output logic [6:0]                       seg_left,
	output logic [6:0]                       seg_mid,
	output logic [6:0]                       seg_right,
	output logic                             power_led,
	output logic                             charge_led,
	output logic                             status_mode
);
	localparam int Y_W   = VAL_W + sgsd_pkg::FILT_FRAC;
	localparam int PER_W = 16 + $clog2(sgsd_pkg::CYC_PER_UNIT + 1);
	localparam int HC_W  = $clog2(HOLD_CYC + 1);
	localparam logic [PER_W-1:0] PH_STEP = PER_W'(2 ** sgsd_pkg::FILT_SHIFT);

	generate
		if (VAL_W < 8 || VAL_W > 16 || HOLD_CYC < 1)
		begin : g_bad_param
			$error("sgsd_top: VAL_W must be 8..16 and HOLD_CYC at least 1");
		end
	endgenerate

	function automatic logic [VAL_W:0] mag(input logic signed [VAL_W:0] v);
		return v[VAL_W] ? -v : v;
	endfunction

	function automatic logic [6:0] hex7(input logic [3:0] d);
		logic [6:0] s;
		s = 7'h00;
		unique case (d)
			4'h0: s = 7'h3f;
			4'h1: s = 7'h06;
			4'h2: s = 7'h5b;
			4'h3: s = 7'h4f;
			4'h4: s = 7'h66;
			4'h5: s = 7'h6d;
			4'h6: s = 7'h7d;
			4'h7: s = 7'h07;
			4'h8: s = 7'h7f;
			4'h9: s = 7'h6f;
			4'ha: s = 7'h77;
			4'hb: s = 7'h7c;
			4'hc: s = 7'h39;
			4'hd: s = 7'h5e;
			4'he: s = 7'h79;
			4'hf: s = 7'h71;
		endcase
		return s;
	endfunction

	// register file
	logic [1:0]       sel_r;
	logic             mode_r;
	logic [15:0]      filt_tc_r;
	logic [VAL_W-1:0] trq_lvl_r;
	logic [VAL_W-1:0] spd_lvl_r;
	logic [VAL_W-1:0] acc_lvl_r;
	logic [VAL_W-1:0] dev_lvl_r;
	logic [VAL_W-1:0] pos_rng_r;
	logic [VAL_W-1:0] rot_spd_r;
	logic [VAL_W-1:0] conf_w_r;

	wire wr_ctrl = wr && addr == sgsd_pkg::OFS_CTRL;
	wire wr_tc   = wr && addr == sgsd_pkg::OFS_FILT_TC;
	wire wr_trq  = wr && addr == sgsd_pkg::OFS_TRQ_LVL;
	wire wr_spd  = wr && addr == sgsd_pkg::OFS_SPD_LVL;
	wire wr_acc  = wr && addr == sgsd_pkg::OFS_ACC_LVL;
	wire wr_dev  = wr && addr == sgsd_pkg::OFS_DEV_LVL;
	wire wr_pos  = wr && addr == sgsd_pkg::OFS_POS_RANGE;
	wire wr_rot  = wr && addr == sgsd_pkg::OFS_ROT_SPEED;
	wire wr_conf = wr && addr == sgsd_pkg::OFS_CONF_WIDTH;
	wire [VAL_W-1:0] wval = wdata[VAL_W-1:0];

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sel_r     <= sgsd_pkg::RST_SEL;
			mode_r    <= sgsd_pkg::RST_MODE; // see [R07]
			filt_tc_r <= sgsd_pkg::RST_FILT_TC;
			trq_lvl_r <= VAL_W'(sgsd_pkg::RST_TRQ_LVL);
			spd_lvl_r <= VAL_W'(sgsd_pkg::RST_SPD_LVL);
			acc_lvl_r <= VAL_W'(sgsd_pkg::RST_ACC_LVL);
			dev_lvl_r <= VAL_W'(sgsd_pkg::RST_DEV_LVL);
			pos_rng_r <= VAL_W'(sgsd_pkg::RST_POS_RANGE);
			rot_spd_r <= VAL_W'(sgsd_pkg::RST_ROT_SPEED);
			conf_w_r  <= VAL_W'(sgsd_pkg::RST_CONF_W);
		end
		else
		begin
			if (wr_ctrl)
			begin
				sel_r  <= wdata[sgsd_pkg::CTRL_SEL_LSB +: 2];
				mode_r <= wdata[sgsd_pkg::CTRL_MODE_BIT];
			end
			if (wr_tc)
				filt_tc_r <= wdata[15:0];
			if (wr_trq)
				trq_lvl_r <= wval;
			if (wr_spd)
				spd_lvl_r <= wval;
			if (wr_acc)
				acc_lvl_r <= wval;
			if (wr_dev)
				dev_lvl_r <= wval;
			if (wr_pos)
				pos_rng_r <= wval;
			if (wr_rot)
				rot_spd_r <= wval;
			if (wr_conf)
				conf_w_r <= wval;
		end
	end

	// pins from outside the clock domain
	logic [6:0] pins_s;

	sgsd_sync #(
		.WIDTH (7)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.pin_in   ({deviation_counter_clear, cmd_pulse_in, rev_permit_in, fwd_permit_in,
			charge_in, main_pwr_in, ctrl_pwr_in}),
		.pin_sync (pins_s)
	);

	wire ctrl_pwr_s = pins_s[0];
	wire main_pwr_s = pins_s[1];
	wire charge_s   = pins_s[2];
	wire fwd_ok_s   = pins_s[3];
	wire rev_ok_s   = pins_s[4];
	wire pulse_s    = pins_s[5];
	wire clear_s    = pins_s[6];

	// feedback filter: step of err/16 every tc/16, which keeps the time
	// constant without a divider; periods under 16 cycles bypass the filter
	logic signed [Y_W-1:0] y_r;
	logic [PER_W-1:0]      phase_r;

	wire [PER_W-1:0] period    = PER_W'(filt_tc_r) * PER_W'(sgsd_pkg::CYC_PER_UNIT);
	wire [PER_W-1:0] phase_nxt = phase_r + PH_STEP;
	wire             filt_byp  = period < PH_STEP;
	wire             filt_tick = phase_nxt >= period;
	wire signed [Y_W-1:0] x_ext = {speed_fb, {sgsd_pkg::FILT_FRAC{1'b0}}};
	wire signed [Y_W:0]   f_err = {x_ext[Y_W-1], x_ext} - {y_r[Y_W-1], y_r};
	wire signed [Y_W:0]   f_stp = f_err >>> sgsd_pkg::FILT_SHIFT;
	wire signed [Y_W-1:0] y_nxt = y_r + $signed(f_stp[Y_W-1:0]);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			phase_r <= '0;
			y_r     <= '0;
		end
		else if (filt_byp)
		begin
			phase_r <= '0;
			y_r     <= x_ext; // see [R01]
		end
		else if (filt_tick)
		begin
			phase_r <= phase_nxt - period;
			y_r     <= y_nxt; // see [R01]
		end
		else
			phase_r <= phase_nxt;
	end

	assign speed_fb_filt = y_r[Y_W-1 -: VAL_W];

	// magnitudes, sign-extended by one bit so the most negative value is safe
	wire [VAL_W:0] trq_m  = mag({torque_cmd[VAL_W-1], torque_cmd});
	wire [VAL_W:0] spd_m  = mag({speed_cmd[VAL_W-1], speed_cmd});
	wire [VAL_W:0] acc_m  = mag({accel_cmd[VAL_W-1], accel_cmd});
	wire [VAL_W:0] dev_m  = mag({deviation[VAL_W-1], deviation});
	wire [VAL_W:0] fb_m   = mag({speed_fb[VAL_W-1], speed_fb});
	wire signed [VAL_W:0] sp_diff = {speed_fb[VAL_W-1], speed_fb} - {speed_cmd[VAL_W-1], speed_cmd};
	wire [VAL_W:0] diff_m = mag(sp_diff);

	wire over_trq = trq_m > {1'b0, trq_lvl_r}; // see [R02]
	wire over_spd = spd_m > {1'b0, spd_lvl_r}; // see [R03]
	wire over_acc = acc_m > {1'b0, acc_lvl_r}; // see [R04]
	wire over_dev = dev_m > {1'b0, dev_lvl_r}; // see [R05]
	wire p_nxt    = sel_r == sgsd_pkg::SEL_TORQUE ? over_trq :
	                sel_r == sgsd_pkg::SEL_SPEED  ? over_spd :
	                sel_r == sgsd_pkg::SEL_ACCEL  ? over_acc : over_dev;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			p_control <= 1'b0;
		else
			p_control <= p_nxt; // see [R06]
	end

	// command pulse activity: an edge restarts a hold window
	logic            pulse_d_r;
	logic [HC_W-1:0] hold_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pulse_d_r <= 1'b0;
			hold_r    <= '0;
		end
		else
		begin
			pulse_d_r <= pulse_s;
			if (pulse_s != pulse_d_r)
				hold_r <= HC_W'(HOLD_CYC); // see [R13]
			else if (hold_r != '0)
				hold_r <= hold_r - 1'b1;
		end
	end

	// base-block dimming: short duty when the servo is on
	logic [sgsd_pkg::DIM_W-1:0] dim_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			dim_r <= '0;
		else
			dim_r <= dim_r + 1'b1;
	end

	logic [sgsd_pkg::LED_N-1:0] led_nxt;
	wire trq_lit = trq_m >= (VAL_W+1)'(sgsd_pkg::TRQ_CMD_PCT); // see [R16]

	assign led_nxt[sgsd_pkg::LED_CTRL_PWR]   = ctrl_pwr_s; // see [R08]
	assign led_nxt[sgsd_pkg::LED_MAIN_PWR]   = main_pwr_s; // see [R08]
	assign led_nxt[sgsd_pkg::LED_BASE_BLOCK] = !servo_on || dim_r == '0; // see [R09]
	assign led_nxt[sgsd_pkg::LED_POS_DONE]   = dev_m < {1'b0, pos_rng_r}; // see [R10]
	assign led_nxt[sgsd_pkg::LED_SPD_CONF]   = diff_m <= {1'b0, conf_w_r}; // see [R11]
	assign led_nxt[sgsd_pkg::LED_ROT_DET]    = fb_m >= {1'b0, rot_spd_r}; // see [R12]
	assign led_nxt[sgsd_pkg::LED_CMD_PULSE]  = hold_r != '0; // see [R13]
	assign led_nxt[sgsd_pkg::LED_SPD_CMD]    = spd_m >= {1'b0, rot_spd_r}; // see [R14]
	assign led_nxt[sgsd_pkg::LED_CLR_TRQ]    = torque_mode ? trq_lit : clear_s; // see [R15]

	// symbol priority: alarm, then overtravel, then servo state
	sgsd_pkg::sgsd_sym_t sym_nxt;
	sgsd_pkg::sgsd_sym_t sym_r;
	assign sym_nxt = alarm_active ? sgsd_pkg::SYM_ALARM : // see [R19]
	                 !fwd_ok_s    ? sgsd_pkg::SYM_POT :   // see [R18]
	                 !rev_ok_s    ? sgsd_pkg::SYM_NOT :   // see [R18]
	                 servo_on     ? sgsd_pkg::SYM_RUN : sgsd_pkg::SYM_BB; // see [R17]

	logic [20:0] seg_nxt;
	always_comb
	begin
		seg_nxt = {3{sgsd_pkg::SEG_BLANK}};
		unique case (sym_nxt)
			sgsd_pkg::SYM_BB:    seg_nxt = {sgsd_pkg::SEG_BLANK, sgsd_pkg::SEG_B, sgsd_pkg::SEG_B};
			sgsd_pkg::SYM_RUN:   seg_nxt = {sgsd_pkg::SEG_R, sgsd_pkg::SEG_U, sgsd_pkg::SEG_N};
			sgsd_pkg::SYM_POT:   seg_nxt = {sgsd_pkg::SEG_P, sgsd_pkg::SEG_O, sgsd_pkg::SEG_T};
			sgsd_pkg::SYM_NOT:   seg_nxt = {sgsd_pkg::SEG_N, sgsd_pkg::SEG_O, sgsd_pkg::SEG_T};
			sgsd_pkg::SYM_ALARM: seg_nxt = {sgsd_pkg::SEG_A, hex7(alarm_code[7:4]),
				hex7(alarm_code[3:0])};
		endcase
	end

	// other display modes live elsewhere; here they blank the status lamps and segments, not the power and charge lamps
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			status_leds <= '0;
			sym_r       <= sgsd_pkg::SYM_BB;
			seg_left    <= sgsd_pkg::SEG_BLANK;
			seg_mid     <= sgsd_pkg::SEG_BLANK;
			seg_right   <= sgsd_pkg::SEG_BLANK;
		end
		else
		begin
			status_leds <= mode_r ? led_nxt : '0; // see [R07]
			sym_r       <= sym_nxt;
			{seg_left, seg_mid, seg_right} <= mode_r ? seg_nxt : '0;
		end
	end

	assign status_mode = mode_r;
	assign power_led   = ctrl_pwr_s; // see [R20]
	assign charge_led  = charge_s; // see [R20]

	// register reads
	wire [sgsd_pkg::DATA_W-1:0] stat_word = sgsd_pkg::DATA_W'({mode_r, sym_r, p_control, status_leds});
	wire [sgsd_pkg::DATA_W-1:0] rd_mux =
		addr == sgsd_pkg::OFS_CTRL       ? sgsd_pkg::DATA_W'({mode_r, sel_r}) :
		addr == sgsd_pkg::OFS_FILT_TC    ? sgsd_pkg::DATA_W'(filt_tc_r) :
		addr == sgsd_pkg::OFS_TRQ_LVL    ? sgsd_pkg::DATA_W'(trq_lvl_r) :
		addr == sgsd_pkg::OFS_SPD_LVL    ? sgsd_pkg::DATA_W'(spd_lvl_r) :
		addr == sgsd_pkg::OFS_ACC_LVL    ? sgsd_pkg::DATA_W'(acc_lvl_r) :
		addr == sgsd_pkg::OFS_DEV_LVL    ? sgsd_pkg::DATA_W'(dev_lvl_r) :
		addr == sgsd_pkg::OFS_POS_RANGE  ? sgsd_pkg::DATA_W'(pos_rng_r) :
		addr == sgsd_pkg::OFS_ROT_SPEED  ? sgsd_pkg::DATA_W'(rot_spd_r) :
		addr == sgsd_pkg::OFS_CONF_WIDTH ? sgsd_pkg::DATA_W'(conf_w_r) :
		addr == sgsd_pkg::OFS_STATUS     ? stat_word :
		addr == sgsd_pkg::OFS_SPEED_FILT ? sgsd_pkg::DATA_W'($unsigned(speed_fb_filt)) : '0;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= '0;
		else
			rdata <= rd ? rd_mux : '0;
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	filt_bypass_a: assert property (filt_tc_r == '0 |=> speed_fb_filt == $past(speed_fb)) // see [R01]
		else $error("filter bypass did not follow input");
	psw_torque_a: assert property ( // see [R02]
		sel_r == sgsd_pkg::SEL_TORQUE && trq_m > {1'b0, trq_lvl_r} |=> p_control)
		else $error("torque switch missed");
	psw_speed_a: assert property ( // see [R03]
		sel_r == sgsd_pkg::SEL_SPEED && spd_m > {1'b0, spd_lvl_r} |=> p_control)
		else $error("speed switch missed");
	psw_accel_a: assert property ( // see [R04]
		sel_r == sgsd_pkg::SEL_ACCEL && acc_m > {1'b0, acc_lvl_r} |=> p_control)
		else $error("accel switch missed");
	psw_dev_a: assert property ( // see [R05]
		sel_r == sgsd_pkg::SEL_DEV && dev_m > {1'b0, dev_lvl_r} |=> p_control)
		else $error("deviation switch missed");
	pi_return_a: assert property ( // see [R06]
		sel_r == sgsd_pkg::SEL_SPEED && spd_m <= {1'b0, spd_lvl_r} |=> !p_control)
		else $error("no return to PI");
	pos_done_a: assert property ( // see [R10]
		mode_r && dev_m < {1'b0, pos_rng_r} |=> status_leds[sgsd_pkg::LED_POS_DONE])
		else $error("positioning lamp wrong");
	rot_lamp_a: assert property ( // see [R12]
		mode_r && fb_m < {1'b0, rot_spd_r} |=> !status_leds[sgsd_pkg::LED_ROT_DET])
		else $error("rotation lamp wrong");
	alarm_sym_a: assert property (alarm_active |=> sym_r == sgsd_pkg::SYM_ALARM) // see [R19]
		else $error("alarm symbol missing");
	bb_dim_a: assert property ( // see [R09]
		mode_r && servo_on |=> !status_leds[sgsd_pkg::LED_BASE_BLOCK]
		|| $past(dim_r) == '0)
		else $error("base block not dimmed");

	p_rise_c: cover property ($rose(p_control));
	run_sym_c: cover property (sym_r == sgsd_pkg::SYM_RUN);
	alarm_c: cover property (sym_r == sgsd_pkg::SYM_ALARM ##1 sym_r == sgsd_pkg::SYM_BB);
endmodule

// ---- verilog/sgsd_pkg.sv ----
// constants for the gain switch and status display block
package sgsd_pkg;
	localparam int         ADDR_W         = 8;
	localparam int         DATA_W         = 32;
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_FILT_TC    = 8'h04;
	localparam logic [7:0] OFS_TRQ_LVL    = 8'h08;
	localparam logic [7:0] OFS_SPD_LVL    = 8'h0c;
	localparam logic [7:0] OFS_ACC_LVL    = 8'h10;
	localparam logic [7:0] OFS_DEV_LVL    = 8'h14;
	localparam logic [7:0] OFS_POS_RANGE  = 8'h18;
	localparam logic [7:0] OFS_ROT_SPEED  = 8'h1c;
	localparam logic [7:0] OFS_CONF_WIDTH = 8'h20;
	localparam logic [7:0] OFS_STATUS     = 8'h24;
	localparam logic [7:0] OFS_SPEED_FILT = 8'h28;
	// control word: [1:0] switch selector, [2] status display mode
	localparam int         CTRL_SEL_LSB   = 0;
	localparam int         CTRL_MODE_BIT  = 2;
	localparam logic [1:0] SEL_TORQUE     = 2'h0;
	localparam logic [1:0] SEL_SPEED      = 2'h1;
	localparam logic [1:0] SEL_ACCEL      = 2'h2;
	localparam logic [1:0] SEL_DEV        = 2'h3;
	localparam logic [1:0] RST_SEL        = 2'h0;
	localparam logic       RST_MODE       = 1'b1;
	localparam logic [15:0] RST_FILT_TC   = 16'h0000;
	localparam logic [15:0] RST_TRQ_LVL   = 16'h00c8;
	localparam logic [15:0] RST_SPD_LVL   = 16'h0000;
	localparam logic [15:0] RST_ACC_LVL   = 16'h0000;
	localparam logic [15:0] RST_DEV_LVL   = 16'h0000;
	localparam logic [15:0] RST_POS_RANGE = 16'h0007;
	localparam logic [15:0] RST_ROT_SPEED = 16'h0014;
	localparam logic [15:0] RST_CONF_W    = 16'h000a;
	// timing
	localparam int CLK_PERIOD_NS  = 100;
	localparam int TC_UNIT_NS     = 10_000;
	localparam int CYC_PER_UNIT   = TC_UNIT_NS / CLK_PERIOD_NS;
	localparam int FILT_SHIFT     = 4;
	localparam int FILT_FRAC      = 8;
	localparam int PULSE_HOLD_NS  = 100_000;
	localparam int PULSE_HOLD_CYC = PULSE_HOLD_NS / CLK_PERIOD_NS;
	localparam int TRQ_CMD_PCT    = 10;
	localparam int DIM_W          = 4;
	// status bit lamps
	localparam int LED_CTRL_PWR   = 0;
	localparam int LED_MAIN_PWR   = 1;
	localparam int LED_BASE_BLOCK = 2;
	localparam int LED_POS_DONE   = 3;
	localparam int LED_SPD_CONF   = 4;
	localparam int LED_ROT_DET    = 5;
	localparam int LED_CMD_PULSE  = 6;
	localparam int LED_SPD_CMD    = 7;
	localparam int LED_CLR_TRQ    = 8;
	localparam int LED_N          = 9;
	typedef enum logic [2:0] {SYM_BB, SYM_RUN, SYM_POT, SYM_NOT, SYM_ALARM} sgsd_sym_t;
	// segments gfedcba
	localparam logic [6:0] SEG_BLANK = 7'h00;
	localparam logic [6:0] SEG_B     = 7'h7c;
	localparam logic [6:0] SEG_R     = 7'h50;
	localparam logic [6:0] SEG_U     = 7'h1c;
	localparam logic [6:0] SEG_N     = 7'h54;
	localparam logic [6:0] SEG_P     = 7'h73;
	localparam logic [6:0] SEG_O     = 7'h5c;
	localparam logic [6:0] SEG_T     = 7'h78;
	localparam logic [6:0] SEG_A     = 7'h77;
endpackage

// ---- verilog/sgsd_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module sgsd_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] meta_r;

	generate
		for (genvar i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					meta_r[i]   <= 1'b0;
					pin_sync[i] <= 1'b0;
				end
				else
				begin
					meta_r[i]   <= pin_in[i];
					pin_sync[i] <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule

// ---- test/sgsd_partner.sv ----
// far-side model: supply, limit, clear and command pulse pins seen by the drive
`timescale 1ns/100ps
module sgsd_partner (
	input  wire logic       clk,
	input  wire logic [5:0] pin_lvl,
	input  wire logic       pulsing,
	output logic      [5:0] pin_out,
	output logic            cmd_pulse
);
	logic [1:0] div_r;
	assign pin_out = pin_lvl;
	initial
	begin
		div_r = 2'h0;
		cmd_pulse = 1'b0;
	end
	// pulse line parked low between moves, period of four clocks while moving
	always @(posedge clk)
	begin
		div_r <= div_r + 2'h1;
		cmd_pulse <= pulsing & div_r[1];
	end
endmodule

// ---- test/sgsd_top_tb.sv ----
// self-checking bench for the gain switch and status display block
`timescale 1ns/100ps
module sgsd_top_tb;
	localparam int HOLD = 20;
	localparam logic [7:0] OFS [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
		8'h18, 8'h1c, 8'h20, 8'h2c};
	localparam logic [7:0] LVL [4] = '{sgsd_pkg::OFS_TRQ_LVL, sgsd_pkg::OFS_SPD_LVL,
		sgsd_pkg::OFS_ACC_LVL, sgsd_pkg::OFS_DEV_LVL};
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic [7:0]         addr = 8'h00;
	logic [31:0]        wdata = 32'h0000_0000;
	logic               wr = 1'b0;
	logic               rd = 1'b0;
	logic signed [15:0] fb = 16'sh0000;
	logic signed [15:0] cmd = 16'sh0000;
	logic signed [15:0] trq = 16'sh0000;
	logic signed [15:0] acc = 16'sh0000;
	logic signed [15:0] dev = 16'sh0000;
	logic               son = 1'b0;
	logic               tmode = 1'b0;
	logic               alarm = 1'b0;
	logic [7:0]         acode = 8'h00;
	logic [5:0]         pins = 6'h3f;
	logic               pulsing = 1'b0;
	logic [5:0]         pin_out;
	logic               cpulse;
	logic [31:0]        rdata;
	logic signed [15:0] filt;
	logic               p_ctl;
	logic [8:0]         leds;
	logic [6:0]         seg_l;
	logic [6:0]         seg_m;
	logic [6:0]         seg_r;
	logic               pwr_led;
	logic               chg_led;
	logic               smode;
	integer             fail_count = 0;
	integer             samples_checked = 0;
	integer             seed = 32'hd590e0b3;
	int                 i;
	int                 s;
	int                 k;
	always #50 clk = ~clk;
	sgsd_partner far_side (.clk(clk), .pin_lvl(pins), .pulsing(pulsing), .pin_out(pin_out),
		.cmd_pulse(cpulse));
	sgsd_top #(.VAL_W(16), .HOLD_CYC(HOLD)) DUT (.clk(clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .speed_fb(fb), .speed_cmd(cmd),
		.torque_cmd(trq), .accel_cmd(acc), .deviation(dev), .servo_on(son),
		.torque_mode(tmode), .alarm_active(alarm), .alarm_code(acode),
		.ctrl_pwr_in(pin_out[0]), .main_pwr_in(pin_out[1]), .charge_in(pin_out[2]),
		.fwd_permit_in(pin_out[3]), .rev_permit_in(pin_out[4]), .cmd_pulse_in(cpulse),
		.deviation_counter_clear(pin_out[5]), .speed_fb_filt(filt), .p_control(p_ctl),
		.status_leds(leds), .seg_left(seg_l), .seg_mid(seg_m), .seg_right(seg_r),
		.power_led(pwr_led), .charge_led(chg_led), .status_mode(smode));
	task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// pins need two sync flops plus the output flop, so four edges is enough
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic drive_q(input int sel, input logic signed [15:0] q);
		@(posedge clk);
		trq <= (sel == 0) ? q : 16'sd30000;
		cmd <= (sel == 1) ? q : 16'sd30000;
		acc <= (sel == 2) ? q : 16'sd30000;
		dev <= (sel == 3) ? q : 16'sd30000;
	endtask
	function automatic int mag(input logic signed [15:0] v);
		return (v < 0) ? -int'(v) : int'(v);
	endfunction
	function automatic logic [8:0] exp_leds();
		logic [8:0] e;
		e[0] = pins[0];
		e[1] = pins[1];
		e[2] = ~son;
		e[3] = mag(dev) < int'(sgsd_pkg::RST_POS_RANGE);
		e[4] = mag(16'(fb - cmd)) <= int'(sgsd_pkg::RST_CONF_W);
		e[5] = mag(fb) >= int'(sgsd_pkg::RST_ROT_SPEED);
		e[6] = 1'b0;
		e[7] = mag(cmd) >= int'(sgsd_pkg::RST_ROT_SPEED);
		e[8] = tmode ? mag(trq) >= sgsd_pkg::TRQ_CMD_PCT : pins[5];
		return e;
	endfunction
	function automatic logic [2:0] exp_sym();
		return alarm ? 3'h4 : !pins[3] ? 3'h2 : !pins[4] ? 3'h3 : son ? 3'h1 : 3'h0;
	endfunction
	// alarm digits carry the code, only the left digit is fixed
	function automatic logic [20:0] exp_seg();
		case (exp_sym())
			3'h0: return {sgsd_pkg::SEG_BLANK, sgsd_pkg::SEG_B, sgsd_pkg::SEG_B};
			3'h1: return {sgsd_pkg::SEG_R, sgsd_pkg::SEG_U, sgsd_pkg::SEG_N};
			3'h2: return {sgsd_pkg::SEG_P, sgsd_pkg::SEG_O, sgsd_pkg::SEG_T};
			3'h3: return {sgsd_pkg::SEG_N, sgsd_pkg::SEG_O, sgsd_pkg::SEG_T};
			default: return {sgsd_pkg::SEG_A, 14'h0000};
		endcase
	endfunction
	task automatic results;
		$display("checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge clk);
		fail_count++;
		results;
	end
	initial
	begin
		logic [31:0] d;
		logic [31:0] rv [10];
		logic [15:0] lvl;
		logic signed [15:0] q;
		logic [8:0] m;
		logic [20:0] sm;
		rv = '{32'h0000_0004, 32'(sgsd_pkg::RST_FILT_TC), 32'(sgsd_pkg::RST_TRQ_LVL),
			32'(sgsd_pkg::RST_SPD_LVL), 32'(sgsd_pkg::RST_ACC_LVL), 32'(sgsd_pkg::RST_DEV_LVL),
			32'(sgsd_pkg::RST_POS_RANGE), 32'(sgsd_pkg::RST_ROT_SPEED),
			32'(sgsd_pkg::RST_CONF_W), 32'h0000_0000};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1 chk_word("status mode", 1, smode);
		wr_reg(8'h2c, 32'hffff_ffff);
		for (i = 0; i < 10; i++)
		begin
			rd_reg(OFS[i], d);
			chk_word("reset value", rv[i], d);
		end
		$display("test reset done");
		for (s = 0; s < 4; s++)
		begin
			wr_reg(sgsd_pkg::OFS_CTRL, 32'h0000_0004 | s);
			lvl = 16'($unsigned($random(seed)) % 1000);
			wr_reg(LVL[s], {16'h0000, lvl});
			rd_reg(LVL[s], d);
			chk_word("level readback", {16'h0000, lvl}, d);
			for (k = 0; k < 10; k++)
			begin
				if (k == 0)
					q = 16'(lvl + 16'h0001);
				else if (k == 1)
					q = -lvl;
				else
					q = 16'($random(seed) % 1100);
				drive_q(s, q);
				settle;
				chk_word("p control", mag(q) > lvl, p_ctl);
			end
		end
		$display("test switch done");
		for (k = 0; k < 6; k++)
		begin
			q = 16'($random(seed));
			@(posedge clk);
			fb <= q;
			@(posedge clk);
			#1 chk_word("filter bypass", {16'h0000, q}, {16'h0000, filt});
		end
		@(posedge clk);
		fb <= 16'sh0000;
		settle;
		// one unit is 100 clocks, so 200 clocks is two time constants
		wr_reg(sgsd_pkg::OFS_FILT_TC, 32'h0000_0001);
		fb <= 16'sd1000;
		repeat (200) @(posedge clk);
		#1 chk_word("filter lag", 1, filt > 16'sd800 && filt < 16'sd950);
		wr_reg(sgsd_pkg::OFS_FILT_TC, 32'h0000_0000);
		$display("test filter done");
		for (k = 0; k < 12; k++)
		begin
			@(posedge clk);
			fb <= 16'($random(seed) % 40);
			cmd <= 16'($random(seed) % 40);
			trq <= 16'($random(seed) % 20);
			dev <= 16'($random(seed) % 12);
			pins <= (k == 0) ? 6'h3f : 6'($random(seed));
			tmode <= k[0];
			son <= k[1];
			alarm <= (k % 5) == 4;
			acode <= 8'($random(seed));
			settle;
			// dimmed lamp blinks with servo on, so it is checked separately
			m = son ? 9'h1fb : 9'h1ff;
			chk_word("lamps", exp_leds() & m, leds & m);
			chk_word("power lamp", pins[0], pwr_led);
			chk_word("charge lamp", pins[2], chg_led);
			sm = alarm ? 21'h1f_c000 : 21'h1f_ffff;
			chk_word("segments", exp_seg(), {seg_l, seg_m, seg_r} & sm);
			rd_reg(sgsd_pkg::OFS_STATUS, d);
			chk_word("symbol", exp_sym(), d[12:10]);
		end
		$display("test lamps done");
		@(posedge clk);
		son <= 1'b1;
		settle;
		s = 0;
		for (k = 0; k < 32; k++)
		begin
			@(posedge clk);
			#1 s += leds[2];
		end
		chk_word("dim duty", 2, s);
		@(posedge clk);
		pulsing <= 1'b1;
		// the partner may need three clocks to its first edge
		settle;
		repeat (3)
		begin
			settle;
			chk_word("pulse lamp on", 1, leds[6]);
		end
		@(posedge clk);
		pulsing <= 1'b0;
		repeat (HOLD + 8) @(posedge clk);
		#1 chk_word("pulse lamp off", 0, leds[6]);
		$display("test pulse done");
		wr_reg(sgsd_pkg::OFS_CTRL, 32'h0000_0000);
		settle;
		chk_word("blank display", 0, {leds, seg_l, seg_m, seg_r, smode});
		$display("test mode done");
		results;
	end
endmodule
